// *** core/ftpc_checker.sv ***
// Top of the far transfer privilege checker: AHB-Lite register slave, sequencing and status.
// Assumes a single AHB-Lite master issuing single word transfers with no overlap of phases.
`timescale 1ns/1ps

module ftpc_checker
  import ftpc_pkg::*;
(
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp
);

  ftpc_state_e   state_reg;
  ftpc_priv_t    cur_priv_reg;
  logic          jump_reg;
  logic          gate_mode_reg;
  logic [15:0]   tgt_sel_reg;
  logic [31:0]   tgt_ofs_reg;
  logic [31:0]   gate_lo_reg;
  logic [31:0]   gate_hi_reg;
  logic [31:0]   dest_lo_reg;
  logic [31:0]   dest_hi_reg;
  logic [1:0]    gate_tbl_reg;
  ftpc_status_s  status_reg;
  logic [31:0]   entry_reg;
  logic [15:0]   stack_info_reg;
  logic          wr_pend_reg;
  logic [7:0]    wr_addr_reg;
  logic [31:0]   rd_next;
  logic          addr_take;
  logic          wr_ctrl;
  logic          wr_idle;
  logic          start;
  ftpc_fault_t   gate_fault;
  ftpc_fault_t   dest_fault;
  ftpc_verdict_s verdict;
  ftpc_status_s  status_view;
  ftpc_code_s    dest_view;
  ftpc_gate_s    gate_view;

  // AHB-Lite address phase; only word transfers carry meaning
  assign addr_take = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign wr_idle   = wr_pend_reg && (state_reg == ST_IDLE);
  assign wr_ctrl   = wr_idle && (wr_addr_reg == OFS_CTRL);
  assign start     = wr_ctrl && hwdata[CTRL_GO_BIT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    status_view      = status_reg;
    status_view.busy = (state_reg != ST_IDLE);
    unique case (haddr[7:0])
      OFS_CTRL:     rd_next = {29'h0, gate_mode_reg, jump_reg, 1'b0};
      OFS_CUR_PRIV: rd_next = {30'h0, cur_priv_reg};
      OFS_TGT_SEL:  rd_next = {16'h0, tgt_sel_reg};
      OFS_TGT_OFS:  rd_next = tgt_ofs_reg;
      OFS_GATE_LO:  rd_next = gate_lo_reg;
      OFS_GATE_HI:  rd_next = gate_hi_reg;
      OFS_DEST_LO:  rd_next = dest_lo_reg;
      OFS_DEST_HI:  rd_next = dest_hi_reg;
      OFS_GATE_TBL: rd_next = {30'h0, gate_tbl_reg};
      OFS_STATUS:   rd_next = status_view;
      OFS_ENTRY:    rd_next = entry_reg;
      OFS_STACK:    rd_next = {16'h0, stack_info_reg};
      default:      rd_next = 32'h0000_0000;
    endcase
  end

  // Read data is fetched in the address phase so it stands for the whole data phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rd_next;
    end
  end

  // Operand registers; writes are ignored while a check runs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      jump_reg      <= 1'b0;
      gate_mode_reg <= 1'b0;
      tgt_sel_reg   <= 16'h0000;
      tgt_ofs_reg   <= WORD_RST;
      gate_lo_reg   <= WORD_RST;
      gate_hi_reg   <= WORD_RST;
      dest_lo_reg   <= WORD_RST;
      dest_hi_reg   <= WORD_RST;
      gate_tbl_reg  <= TBL_RST;
    end else if (wr_idle) begin
      unique case (wr_addr_reg)
        OFS_CTRL: begin
          jump_reg      <= hwdata[CTRL_JUMP_BIT];
          gate_mode_reg <= hwdata[CTRL_GATE_BIT];
        end
        OFS_TGT_SEL:  tgt_sel_reg  <= hwdata[15:0];
        OFS_TGT_OFS:  tgt_ofs_reg  <= hwdata;
        OFS_GATE_LO:  gate_lo_reg  <= hwdata;
        OFS_GATE_HI:  gate_hi_reg  <= hwdata;
        OFS_DEST_LO:  dest_lo_reg  <= hwdata;
        OFS_DEST_HI:  dest_hi_reg  <= hwdata;
        OFS_GATE_TBL: gate_tbl_reg <= hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // The go write carries its own mode bits, registered on the same edge as go, so the checker sees them in ST_GATE
  ftpc_rules u_rules (
    .cur_priv   (cur_priv_reg),
    .via_gate   (gate_mode_reg),
    .is_jump    (jump_reg),
    .gate_tbl   (gate_tbl_reg),
    .tgt_sel    (tgt_sel_reg),
    .tgt_ofs    (tgt_ofs_reg),
    .gate_lo    (gate_lo_reg),
    .gate_hi    (gate_hi_reg),
    .dest_lo    (dest_lo_reg),
    .dest_hi    (dest_hi_reg),
    .gate_fault (gate_fault),
    .dest_fault (dest_fault),
    .verdict    (verdict)
  );

  assign dest_view = ftpc_decode_code(dest_lo_reg, dest_hi_reg);
  assign gate_view = ftpc_decode_gate(gate_lo_reg, gate_hi_reg);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (start) state_reg <= ST_GATE;
        ST_GATE: state_reg <= (gate_fault == FLT_NONE) ? ST_DEST : ST_IDLE;
        ST_DEST: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Current level: software load when idle, lowered only by a passing call down
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur_priv_reg <= CUR_PRIV_RST;
    end else if (state_reg == ST_DEST && dest_fault == FLT_NONE) begin
      cur_priv_reg <= verdict.new_priv;
    end else if (wr_idle && wr_addr_reg == OFS_CUR_PRIV) begin
      cur_priv_reg <= hwdata[1:0];
    end
  end

  // Result flags: cleared by go, set at the end of a check; the two never coincide
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_reg <= '0;
    end else if (start) begin
      status_reg <= '0;
    end else if (state_reg == ST_GATE && gate_fault != FLT_NONE) begin
      status_reg.done     <= 1'b1;
      status_reg.fault    <= gate_fault;
      status_reg.gp_fault <= (gate_fault != FLT_NOT_PRES);
      status_reg.np_fault <= (gate_fault == FLT_NOT_PRES);
    end else if (state_reg == ST_DEST) begin
      status_reg.done <= 1'b1;
      if (dest_fault != FLT_NONE) begin
        status_reg.fault    <= dest_fault;
        status_reg.gp_fault <= (dest_fault != FLT_NOT_PRES);
        status_reg.np_fault <= (dest_fault == FLT_NOT_PRES);
      end else begin
        status_reg.stack_switch <= verdict.stack_switch;
        status_reg.push32       <= verdict.push32;
        status_reg.count        <= verdict.count;
        status_reg.new_priv     <= verdict.new_priv;
        status_reg.dest_local   <= verdict.dest_local;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      entry_reg      <= WORD_RST;
      stack_info_reg <= 16'h0000;
    end else if (start) begin
      entry_reg      <= WORD_RST;
      stack_info_reg <= 16'h0000;
    end else if (state_reg == ST_DEST && dest_fault == FLT_NONE) begin
      entry_reg      <= verdict.entry;
      stack_info_reg <= {verdict.push_bytes, verdict.copy_bytes};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_launch;
    start ##1 (state_reg == ST_GATE);
  endsequence

  sequence s_dest_pass;
    (state_reg == ST_DEST) && (dest_fault == FLT_NONE);
  endsequence

  property p_launch_done;
    start |-> s_launch ##[1:2] status_reg.done;
  endproperty
  a_launch_done: assert property (p_launch_done) else $error("check did not finish");

  property p_gate_first;
    (state_reg == ST_DEST) |-> $past(state_reg) == ST_GATE && $past(gate_fault) == FLT_NONE;
  endproperty
  a_gate_first: assert property (p_gate_first) else $error("dest check before gate");

  property p_idt_refused;
    (state_reg == ST_GATE && gate_mode_reg && gate_tbl_reg == TBL_INTERRUPT)
      |=> status_reg.gp_fault && state_reg == ST_IDLE;
  endproperty
  a_idt_refused: assert property (p_idt_refused) else $error("interrupt table gate taken");

  property p_gate_cpl;
    (state_reg == ST_GATE && gate_mode_reg && cur_priv_reg > gate_view.descriptor_priv_level)
      |=> status_reg.gp_fault && status_reg.done;
  endproperty
  a_gate_cpl: assert property (p_gate_cpl) else $error("gate level check missed");

  property p_gate_rpl;
    (state_reg == ST_GATE && gate_mode_reg && tgt_sel_reg[1:0] > gate_view.descriptor_priv_level)
      |=> status_reg.gp_fault && status_reg.done && state_reg == ST_IDLE;
  endproperty
  a_gate_rpl: assert property (p_gate_rpl) else $error("gate rpl check missed");

  property p_not_present;
    (state_reg == ST_GATE && gate_mode_reg && gate_tbl_reg < TBL_INTERRUPT
      && gate_view.is_call_gate && cur_priv_reg <= gate_view.descriptor_priv_level
      && tgt_sel_reg[1:0] <= gate_view.descriptor_priv_level && !gate_view.present)
      |=> status_reg.np_fault && !status_reg.gp_fault && state_reg == ST_IDLE;
  endproperty
  a_not_present: assert property (p_not_present) else $error("absent target not flagged");

  property p_conf_keeps;
    (s_dest_pass and dest_view.conforming)
      |=> cur_priv_reg == $past(cur_priv_reg) && !status_reg.stack_switch;
  endproperty
  a_conf_keeps: assert property (p_conf_keeps) else $error("conforming changed level");

  property p_call_down;
    (s_dest_pass and gate_mode_reg && !jump_reg && !dest_view.conforming
      && dest_view.descriptor_priv_level < cur_priv_reg)
      |=> cur_priv_reg == $past(dest_view.descriptor_priv_level) && status_reg.stack_switch;
  endproperty
  a_call_down: assert property (p_call_down) else $error("call down not switched");

  property p_jump_equal;
    (state_reg == ST_DEST && gate_mode_reg && jump_reg && dest_view.is_code
      && dest_view.present && !dest_view.conforming && dest_view.descriptor_priv_level != cur_priv_reg)
      |=> status_reg.gp_fault && status_reg.fault == FLT_DEST_PRIV;
  endproperty
  a_jump_equal: assert property (p_jump_equal) else $error("jump level not equal");

  property p_call_nonconf;
    (state_reg == ST_DEST && gate_mode_reg && !jump_reg && dest_view.is_code
      && dest_view.present && !dest_view.conforming && dest_view.descriptor_priv_level > cur_priv_reg)
      |=> status_reg.gp_fault && status_reg.fault == FLT_DEST_PRIV;
  endproperty
  a_call_nonconf: assert property (p_call_nonconf) else $error("call to outer level taken");

  // Operands and level cannot move in the cycle after the check, so they are read there
  property p_gate_conf;
    (state_reg == ST_DEST && gate_mode_reg && dest_view.is_code && dest_view.present
      && dest_view.conforming) |=> status_reg.gp_fault == (dest_view.descriptor_priv_level > cur_priv_reg);
  endproperty
  a_gate_conf: assert property (p_gate_conf) else $error("conforming gate level wrong");

  property p_direct_nonconf;
    (state_reg == ST_DEST && !gate_mode_reg && dest_view.is_code && dest_view.present
      && !dest_view.conforming && dest_view.descriptor_priv_level != cur_priv_reg) |=> status_reg.gp_fault;
  endproperty
  a_direct_nonconf: assert property (p_direct_nonconf) else $error("direct level mismatch");

  property p_direct_conf;
    (state_reg == ST_DEST && !gate_mode_reg && dest_view.is_code && dest_view.present
      && dest_view.conforming && cur_priv_reg >= dest_view.descriptor_priv_level) |=> !status_reg.gp_fault;
  endproperty
  a_direct_conf: assert property (p_direct_conf) else $error("conforming wrongly refused");

  property p_entry;
    (s_dest_pass and gate_mode_reg)
      |=> entry_reg == $past(dest_view.base) + $past(gate_view.offset);
  endproperty
  a_entry: assert property (p_entry) else $error("entry address wrong");

  property p_gate_fields;
    (s_dest_pass and gate_mode_reg)
      |=> status_reg.push32 == gate_view.wide && status_reg.count == gate_view.count
      && status_reg.dest_local == gate_view.sel[SEL_TI_BIT];
  endproperty
  a_gate_fields: assert property (p_gate_fields) else $error("gate fields lost");

endmodule : ftpc_checker

// *** core/ftpc_pkg.sv ***
// Shared constants, types and descriptor decoders of the far transfer privilege checker.
// Assumes software loads descriptor words and operands over an AHB-Lite register bus.
package ftpc_pkg;

  typedef logic [1:0] ftpc_priv_t;
  typedef logic [2:0] ftpc_fault_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CUR_PRIV = 8'h04;
  localparam logic [7:0] OFS_TGT_SEL  = 8'h08;
  localparam logic [7:0] OFS_TGT_OFS  = 8'h0C;
  localparam logic [7:0] OFS_GATE_LO  = 8'h10;
  localparam logic [7:0] OFS_GATE_HI  = 8'h14;
  localparam logic [7:0] OFS_DEST_LO  = 8'h18;
  localparam logic [7:0] OFS_DEST_HI  = 8'h1C;
  localparam logic [7:0] OFS_GATE_TBL = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_ENTRY    = 8'h28;
  localparam logic [7:0] OFS_STACK    = 8'h2C;

  // Control register bits
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_JUMP_BIT = 1;
  localparam int unsigned CTRL_GATE_BIT = 2;

  // Values after reset
  localparam ftpc_priv_t  CUR_PRIV_RST = 2'h0;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  localparam logic [1:0]  TBL_RST      = 2'h0;

  // Table that held the gate
  localparam logic [1:0] TBL_GLOBAL    = 2'h0;
  localparam logic [1:0] TBL_LOCAL     = 2'h1;
  localparam logic [1:0] TBL_INTERRUPT = 2'h2;

  // Selector fields
  localparam int unsigned SEL_TI_BIT  = 2;

  // Descriptor high word fields
  localparam int unsigned HI_COUNT_LSB = 0;
  localparam int unsigned HI_CONF_BIT  = 10;
  localparam int unsigned HI_WIDE_BIT  = 11;
  localparam int unsigned HI_CODE_BIT  = 11;
  localparam int unsigned HI_S_BIT     = 12;
  localparam int unsigned HI_DPL_LSB   = 13;
  localparam int unsigned HI_P_BIT     = 15;
  localparam logic [2:0]  GATE_TYPE_LOW = 3'h4;

  // Stack push widths in bytes, and the four fixed pushes of a stack switch
  localparam logic [7:0] NARROW_BYTES = 8'h02;
  localparam logic [7:0] WIDE_BYTES   = 8'h04;
  localparam logic [7:0] FIXED_PUSHES = 8'h04;

  // Fault codes
  localparam ftpc_fault_t FLT_NONE      = 3'h0;
  localparam ftpc_fault_t FLT_GATE_TBL  = 3'h1;
  localparam ftpc_fault_t FLT_GATE_TYPE = 3'h2;
  localparam ftpc_fault_t FLT_GATE_PRIV = 3'h3;
  localparam ftpc_fault_t FLT_NOT_PRES  = 3'h4;
  localparam ftpc_fault_t FLT_DEST_TYPE = 3'h5;
  localparam ftpc_fault_t FLT_DEST_PRIV = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GATE = 2'b01,
    ST_DEST = 2'b10
  } ftpc_state_e;

  typedef struct packed {
    logic [31:0] offset;
    logic [15:0] sel;
    ftpc_priv_t  descriptor_priv_level;
    logic        present;
    logic        is_call_gate;
    logic        wide;
    logic [4:0]  count;
  } ftpc_gate_s;

  typedef struct packed {
    logic [31:0] base;
    ftpc_priv_t  descriptor_priv_level;
    logic        present;
    logic        conforming;
    logic        is_code;
  } ftpc_code_s;

  typedef struct packed {
    ftpc_priv_t  new_priv;
    logic        stack_switch;
    logic        push32;
    logic [4:0]  count;
    logic        dest_local;
    logic [31:0] entry;
    logic [7:0]  copy_bytes;
    logic [7:0]  push_bytes;
  } ftpc_verdict_s;

  typedef struct packed {
    logic [14:0] rsvd;
    ftpc_fault_t fault;
    logic        dest_local;
    ftpc_priv_t  new_priv;
    logic [4:0]  count;
    logic        push32;
    logic        stack_switch;
    logic        np_fault;
    logic        gp_fault;
    logic        done;
    logic        busy;
  } ftpc_status_s;

  function automatic ftpc_gate_s ftpc_decode_gate(input logic [31:0] lo, input logic [31:0] hi);
    ftpc_gate_s g;
    g.offset       = {hi[31:16], lo[15:0]};
    g.sel          = lo[31:16];
    g.descriptor_priv_level          = hi[HI_DPL_LSB +: 2];
    g.present      = hi[HI_P_BIT];
    g.is_call_gate = (hi[HI_CONF_BIT -: 3] == GATE_TYPE_LOW) && !hi[HI_S_BIT];
    g.wide         = hi[HI_WIDE_BIT];
    g.count        = hi[HI_COUNT_LSB +: 5];
    return g;
  endfunction : ftpc_decode_gate

  function automatic ftpc_code_s ftpc_decode_code(input logic [31:0] lo, input logic [31:0] hi);
    ftpc_code_s c;
    c.base       = {hi[31:24], hi[7:0], lo[31:16]};
    c.descriptor_priv_level        = hi[HI_DPL_LSB +: 2];
    c.present    = hi[HI_P_BIT];
    c.conforming = hi[HI_CONF_BIT];
    c.is_code    = hi[HI_S_BIT] && hi[HI_CODE_BIT];
    return c;
  endfunction : ftpc_decode_code

endpackage : ftpc_pkg

// *** core/ftpc_rules.sv ***
// Combinational gate-level and destination-level checks of one far transfer.
// Assumes the operands are held stable by the caller while it samples the results.
`timescale 1ns/1ps
module ftpc_rules
  import ftpc_pkg::*;
(
  input  ftpc_priv_t    cur_priv,
  input  logic          via_gate,
  input  logic          is_jump,
  input  logic [1:0]    gate_tbl,
  input  logic [15:0]   tgt_sel,
  input  logic [31:0]   tgt_ofs,
  input  logic [31:0]   gate_lo,
  input  logic [31:0]   gate_hi,
  input  logic [31:0]   dest_lo,
  input  logic [31:0]   dest_hi,
  output ftpc_fault_t   gate_fault,
  output ftpc_fault_t   dest_fault,
  output ftpc_verdict_s verdict
);

  ftpc_gate_s gate;
  ftpc_code_s dest;
  ftpc_priv_t requested_priv_level;
  logic [7:0] width_bytes;

  assign gate = ftpc_decode_gate(gate_lo, gate_hi);
  assign dest = ftpc_decode_code(dest_lo, dest_hi);
  assign requested_priv_level  = tgt_sel[1:0];

  always_comb begin
    gate_fault = FLT_NONE;
    if (via_gate) begin
      if (gate_tbl == TBL_INTERRUPT || gate_tbl > TBL_INTERRUPT) begin
        gate_fault = FLT_GATE_TBL;
      end else if (!gate.is_call_gate) begin
        gate_fault = FLT_GATE_TYPE;
      end else if (cur_priv > gate.descriptor_priv_level || requested_priv_level > gate.descriptor_priv_level) begin
        gate_fault = FLT_GATE_PRIV;
      end else if (!gate.present) begin
        gate_fault = FLT_NOT_PRES;
      end
    end
  end

  // Conforming flag picks the rule set; selector REQUESTED_PRIV_LEVEL never looked at here
  always_comb begin
    dest_fault = FLT_NONE;
    if (!dest.is_code) begin
      dest_fault = FLT_DEST_TYPE;
    end else if (!dest.present) begin
      dest_fault = FLT_NOT_PRES;
    end else if (dest.conforming) begin
      if (cur_priv < dest.descriptor_priv_level) begin
        dest_fault = FLT_DEST_PRIV;
      end
    end else if (!via_gate || is_jump) begin
      if (dest.descriptor_priv_level != cur_priv) begin
        dest_fault = FLT_DEST_PRIV;
      end
    end else if (dest.descriptor_priv_level > cur_priv) begin
      dest_fault = FLT_DEST_PRIV;
    end
  end

  assign width_bytes = gate.wide ? WIDE_BYTES : NARROW_BYTES;

  always_comb begin
    verdict              = '0;
    verdict.stack_switch = via_gate && !is_jump && !dest.conforming
                           && dest.descriptor_priv_level < cur_priv;
    verdict.new_priv     = verdict.stack_switch ? dest.descriptor_priv_level : cur_priv;
    verdict.push32       = via_gate && gate.wide;
    verdict.count        = via_gate ? gate.count : 5'h00;
    verdict.dest_local   = via_gate ? gate.sel[SEL_TI_BIT] : tgt_sel[SEL_TI_BIT];
    verdict.entry        = via_gate ? dest.base + gate.offset : dest.base + tgt_ofs;
    verdict.copy_bytes   = 8'(verdict.count * width_bytes);
    verdict.push_bytes   = verdict.stack_switch
                           ? 8'((FIXED_PUSHES + {3'h0, verdict.count}) * width_bytes)
                           : 8'h00;
  end

endmodule : ftpc_rules

// *** test/ftpc_bus_master.sv ***
// Bus master model of the execution unit that issues far transfers to the checker.
// Assumes one AHB-Lite slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
module ftpc_bus_master (
  input  logic        mclk,
  input  logic        hready,
  input  logic [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Released address and data lines carry inverted values so a stale copy never passes for data
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'h1) @(posedge mclk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    haddr  <= ~{24'h0, a};
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'h1) @(posedge mclk);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : ftpc_bus_master

// *** test/ftpc_checker_tb.sv ***
// Self-checking bench of the far transfer privilege checker.
// Assumes ftpc_bus_master is the only bus master and the clock runs at 40 MHz.
`timescale 1ns/1ps
module ftpc_checker_tb
  import ftpc_pkg::*;
;
  logic        mclk;
  logic        sys_rst;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] st;
  logic [31:0] q;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  ftpc_checker dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  ftpc_bus_master bm (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bm.xfer(a, 1'h1, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bm.xfer(a, 1'h0, 32'h0, q);
  endtask : rd

  // Descriptors as {high word, low word}
  function automatic logic [63:0] gate_d(logic [15:0] s, logic [1:0] l, logic p, logic w,
                                         logic [4:0] n);
    return {16'hC001, p, l, 1'h0, w, 3'h4, 3'h0, n, s, 16'h2340};
  endfunction : gate_d

  function automatic logic [63:0] code_d(logic [1:0] l, logic cf);
    return {8'h01, 8'h00, 1'h1, l, 2'h3, cf, 2'h0, 8'h00, 32'h0};
  endfunction : code_d

  task automatic run(input int c, input logic [15:0] s, input logic [63:0] g,
                     input logic [63:0] k, input logic [1:0] t, input logic [2:0] m);
    int n;
    wr(OFS_CUR_PRIV, c);
    wr(OFS_TGT_SEL, {16'h0, s});
    wr(OFS_TGT_OFS, 32'h5A5A_0F0F);
    wr(OFS_GATE_LO, g[31:0]);
    wr(OFS_GATE_HI, g[63:32]);
    wr(OFS_DEST_LO, k[31:0]);
    wr(OFS_DEST_HI, k[63:32]);
    wr(OFS_GATE_TBL, {30'h0, t});
    wr(OFS_CTRL, {29'h0, m});
    n = 0;
    st = 32'h0;
    while (st[1] !== 1'h1 && n < 20) begin
      rd(OFS_STATUS);
      st = q;
      n++;
    end
    chk({31'h0, st[1]}, 32'h1, "done");
  endtask : run

  // Expected e = {dest in local table, new level, stack switch}
  task automatic judge(input ftpc_fault_t f, input logic [3:0] e);
    chk({29'h0, st[16:14]}, {29'h0, f}, "fault code");
    chk({30'h0, st[3:2]}, {30'h0, f == FLT_NOT_PRES, f != FLT_NONE && f != FLT_NOT_PRES}, "flags");
    if (f == FLT_NONE)
      chk({28'h0, st[13:11], st[4]}, {28'h0, e}, "level/switch");
  endtask : judge

  task automatic t_regs();
    rd(OFS_CUR_PRIV);
    chk(q, 32'h0, "level reset");
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS);
    chk(q, 32'h0, "status ro");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk(q, 32'h0, "unmapped");
    wr(OFS_CUR_PRIV, 32'h3);
    rd(OFS_CUR_PRIV);
    chk(q, 32'h3, "level rw");
    chk({31'h0, hresp}, 32'h0, "response okay");
  endtask : t_regs

  task automatic t_direct();
    logic ok;
    for (int cf = 0; cf < 2; cf++)
      for (int c = 0; c < 4; c++)
        for (int d = 0; d < 4; d++) begin
          run(c, 16'h0013, 64'h0, code_d(d[1:0], cf[0]), 2'h0, 3'h1);
          ok = cf ? (c >= d) : (c == d);
          judge(ok ? FLT_NONE : FLT_DEST_PRIV, {1'h0, c[1:0], 1'h0});
          rd(OFS_ENTRY);
          if (ok) chk(q, 32'h5B5A_0F0F, "direct entry");
        end
  endtask : t_direct

  task automatic t_gate();
    logic [1:0] r;
    logic       sw;
    logic       gok;
    logic       dok;
    for (int j = 0; j < 2; j++)
      for (int c = 0; c < 4; c++)
        for (int g = 0; g < 4; g++)
          for (int d = 0; d < 4; d++)
            for (int cf = 0; cf < 2; cf++) begin
              r = 2'h3 - c[1:0];
              gok = (c <= g) && (r <= g);
              dok = (cf || j == 0) ? (d <= c) : (d == c);
              sw = !cf && !j && d < c;
              run(c, {14'h0028, r}, gate_d(16'h0008, g[1:0], 1'h1, 1'h0, 5'h03),
                  code_d(d[1:0], cf[0]), 2'h0, {1'h1, j[0], 1'h1});
              judge(!gok ? FLT_GATE_PRIV : !dok ? FLT_DEST_PRIV : FLT_NONE,
                    {1'h0, sw ? d[1:0] : c[1:0], sw});
              rd(OFS_ENTRY);
              if (gok && dok) chk(q, 32'hC101_2340, "gate entry");
            end
  endtask : t_gate

  task automatic t_table();
    for (int t = 0; t < 4; t++) begin
      run(0, 16'h0000, gate_d({13'h0001, t[0], 2'h0}, 2'h3, 1'h1, 1'h0, 5'h00),
          code_d(2'h0, 1'h1), t[1:0], 3'h5);
      judge(t >= 2 ? FLT_GATE_TBL : FLT_NONE, {t[0], 3'h0});
    end
  endtask : t_table

  task automatic t_stack();
    logic [7:0] b;
    for (int w = 0; w < 2; w++)
      for (int n = 0; n < 32; n += 31) begin
        b = w ? 8'h04 : 8'h02;
        run(3, 16'h0003, gate_d(16'h0008, 2'h3, 1'h1, w[0], n[4:0]), code_d(2'h0, 1'h0),
            2'h0, 3'h5);
        judge(FLT_NONE, 4'h1);
        chk({26'h0, st[10:5]}, {26'h0, n[4:0], w[0]}, "count/width");
        rd(OFS_STACK);
        chk(q, {16'h0, 8'(b * (n + 4)), 8'(b * n)}, "stack bytes");
      end
    run(3, 16'h0003, gate_d(16'h0008, 2'h3, 1'h0, 1'h0, 5'h01), code_d(2'h0, 1'h0), 2'h0,
        3'h5);
    judge(FLT_NOT_PRES, 4'h0);
  endtask : t_stack

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    sys_rst = 1'h1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_direct();
    t_gate();
    t_table();
    t_stack();
    end_of_test();
  end
endmodule : ftpc_checker_tb
